// ==== design/sdram_cmd_pkg.sv ====
// Purpose: Shared types and constants of the SDRAM command and state logic.
// Assumes: Nine column bits, four banks, CAS latency of two or three.
// Notes: Burst length codes follow the usual mode register encoding.

package sdram_cmd_pkg;

	// ==========================================================
	// Burst length codes and the matching column masks
	// ==========================================================
	// Except in full page, the mask is also the index of the last beat of a burst.
	localparam logic [2:0] BL_CODE_1 = 3'h0;
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] BL_CODE_PAGE = 3'h7;
	localparam logic [8:0] MASK_BL1 = 9'h000;
	localparam logic [8:0] MASK_BL2 = 9'h001;
	localparam logic [8:0] MASK_BL4 = 9'h003;
	localparam logic [8:0] MASK_BL8 = 9'h007;
	localparam logic [8:0] MASK_PAGE = 9'h1FF;

	// ==========================================================
	// Auto-precharge lead before the burst end, per CAS latency
	// ==========================================================
	localparam logic [8:0] AP_LEAD_CL2 = 9'h001;
	localparam logic [8:0] AP_LEAD_CL3 = 9'h002;

	// ==========================================================
	// Reset values and the all-banks mask
	// ==========================================================
	localparam logic [3:0] BANKS_NONE = 4'h0;
	localparam logic [3:0] BANKS_ALL = 4'hF;
	localparam logic [8:0] COL_RESET = 9'h000;

	// Power modes, one-hot.
	typedef enum logic [3:0] {
		PM_RUN = 4'b0001,
		PM_SUSP = 4'b0010,
		PM_PDOWN = 4'b0100,
		PM_SREF = 4'b1000
	} pwr_mode_t;

	// Command pins as sampled at the rising clock edge.
	typedef struct packed {
		logic chipSelN;
		logic rowStrobeN;
		logic colStrobeN;
		logic writeEnN;
		logic clockEnable;
		logic a10;
		logic bankSelectHigh;
		logic bankSelectLow;
		logic [8:0] col;
	} cmd_pins_t;

	// Programmed mode, held steady by the caller.
	typedef struct packed {
		logic casLatency3;
		logic interleave;
		logic [2:0] burstCode;
	} mode_cfg_t;

	// Bank and power state as seen from outside.
	typedef struct packed {
		logic [3:0] bankOpen;
		logic [3:0] prechargeBanks;
		logic selfRefresh;
		logic powerDown;
		logic clockSuspend;
		logic burstActive;
	} dev_status_t;

	// One column beat of a burst and the read output enable.
	typedef struct packed {
		logic readBeat;
		logic writeBeat;
		logic dqOutEn;
		logic [1:0] bank;
		logic [8:0] col;
	} beat_t;

endpackage

// ==== design/sdram_cmd_state.sv ====
// Purpose: Command decode, burst sequencing and bank/power state of an SDRAM.
// Assumes: Pins are synchronous to sys_clk; mode is stable during bursts.
// Notes: Activate is decoded only to open banks; no data array is held.
// Behaviour
// - Burst stop acts only in full-page bursts.
// - Stop decoded: row, column high; select, write low.
// - Read stop: outputs float after CAS latency.
// - Write data after a stop is discarded.
// - Sequential order wraps inside burst boundary.
// - Interleaved order inverts low column bits; the code runs full-page bursts in sequential order.
// - A10 high on access requests auto-precharge; the code ignores A10 in full-page bursts.
// - Read auto-precharge starts latency-dependent clocks early.
// - Write auto-precharge one clock after last data.
// - Precharge decoded and closes an active bank.
// - Precharge targets one or all banks.
// - Self refresh entry decode, all banks idle.
// - Self refresh ignores all but clock enable.
// - Clock enable low while idle enters power down.
// - No-operation never ends a running burst.
// - Chip select high is deselect, like no-operation.
// - Clock suspend one clock after enable low.
// - Enable low in a burst means suspend.

`timescale 1ns/1ps

module sdram_cmd_state
	import sdram_cmd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire cmd_pins_t cmd,
	input wire mode_cfg_t mode,
	output dev_status_t status,
	output beat_t beat
);

	// ==========================================================
	// Command decode
	// ==========================================================
	// Every decode needs chip select low, so a deselect falls through
	// to no action at all, exactly like a no-operation.
	logic selected; // Chip select asserted.
	logic isAct; // Bank activate.
	logic isRead; // Burst read.
	logic isWrite; // Burst write.
	logic isPre; // Precharge.
	logic isStop; // Burst stop.
	logic isSref; // Self refresh entry.
	logic [1:0] bankIdx; // Bank named by the bank-select inputs.
	logic [3:0] bankBit; // One-hot form of bankIdx.

	assign selected = !cmd.chipSelN;
	assign isAct = selected && !cmd.rowStrobeN && cmd.colStrobeN &&
		cmd.writeEnN;
	assign isRead = selected && cmd.rowStrobeN && !cmd.colStrobeN &&
		cmd.writeEnN;
	assign isWrite = selected && cmd.rowStrobeN && !cmd.colStrobeN &&
		!cmd.writeEnN;
	assign isPre = selected && !cmd.rowStrobeN && cmd.colStrobeN &&
		!cmd.writeEnN;
	assign isStop = selected && cmd.rowStrobeN && cmd.colStrobeN &&
		!cmd.writeEnN;
	assign isSref = selected && !cmd.rowStrobeN && !cmd.colStrobeN &&
		cmd.writeEnN && !cmd.clockEnable;
	assign bankIdx = {cmd.bankSelectHigh, cmd.bankSelectLow};
	assign bankBit = 4'h1 << bankIdx;

	// ==========================================================
	// State registers
	// ==========================================================
	pwr_mode_t pm_ff, nxt_pm; // Power mode.
	logic [3:0] bankOpen_ff, nxt_bankOpen; // Activated banks.
	logic burstOn_ff, nxt_burstOn; // A burst is sequencing.
	logic burstWrite_ff, nxt_burstWrite; // Running burst is a write.
	logic apPend_ff, nxt_apPend; // Auto-precharge still owed.
	logic [1:0] burstBank_ff, nxt_burstBank; // Bank of running burst.
	logic [8:0] start_ff, nxt_start; // Start column of the burst.
	logic [8:0] beatIdx_ff, nxt_beatIdx; // Index of last issued beat.
	logic [1:0] readPipe_ff, nxt_readPipe; // Read beats in latency.
	dev_status_t status_ff, nxt_status; // Registered status.
	beat_t beat_ff, nxt_beat; // Registered beat output.

	// Combinational helpers.
	logic pmRun; // Commands are taken only in run mode.
	logic fullPage; // Programmed burst is a full page.
	logic [8:0] mask; // Column bits that move inside a burst.
	logic [8:0] lead; // Auto-precharge lead for read bursts.
	logic rwOk; // Accepted read or write.
	logic issue; // A beat is issued at this edge.
	logic issueWrite; // The issued beat is a write.
	logic [1:0] issueBank; // Bank of the issued beat.
	logic [8:0] issueBeat; // Index of the issued beat.
	logic [8:0] issueStart; // Start column of the issued beat.
	logic [8:0] issueCol; // Column of the issued beat.
	logic [3:0] closeBanks; // Banks closed at this edge.
	logic [3:0] apClose; // Banks closed by auto-precharge.
	assign pmRun = (pm_ff == PM_RUN);

	// ==========================================================
	// Power mode: run, clock suspend, power down, self refresh
	// ==========================================================
	// Next power mode. A low-power mode starts at the same edge that
	// sees the enable low, so the command sampled with it still runs.
	always_comb begin
		nxt_pm = pm_ff;
		unique case (pm_ff)
			PM_RUN: if (!cmd.clockEnable) begin
				if (isSref && bankOpen_ff == BANKS_NONE && !burstOn_ff) begin
					nxt_pm = PM_SREF;
				end else if (bankOpen_ff != BANKS_NONE || burstOn_ff) begin
					nxt_pm = PM_SUSP;
				end else begin
					nxt_pm = PM_PDOWN;
				end
			end
			// Each low-power mode returns to run once the enable is seen
			// high; no other pin is looked at while it lasts.
			PM_SUSP, PM_PDOWN, PM_SREF: begin
				if (cmd.clockEnable) begin
					nxt_pm = PM_RUN;
				end
			end
		endcase
	end

	// Power mode register.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pm_ff <= PM_RUN;
		end else if (ce) begin
			pm_ff <= nxt_pm;
		end
	end

	// ==========================================================
	// Burst sequencing, auto-precharge and bank state
	// ==========================================================
	// Next burst and bank state. Outside run mode nothing advances,
	// which freezes a suspended burst exactly where it stood.
	always_comb begin
		unique case (mode.burstCode)
			BL_CODE_1: mask = MASK_BL1;
			BL_CODE_2: mask = MASK_BL2;
			BL_CODE_4: mask = MASK_BL4;
			BL_CODE_8: mask = MASK_BL8;
			BL_CODE_PAGE: mask = MASK_PAGE;
			default: mask = MASK_BL1;
		endcase
		fullPage = (mode.burstCode == BL_CODE_PAGE);
		lead = mode.casLatency3 ? AP_LEAD_CL3 : AP_LEAD_CL2;
		// An access to a closed bank is dropped.
		rwOk = pmRun && (isRead || isWrite) && bankOpen_ff[bankIdx];
		nxt_burstOn = burstOn_ff;
		nxt_burstWrite = burstWrite_ff;
		nxt_apPend = apPend_ff;
		nxt_burstBank = burstBank_ff;
		nxt_start = start_ff;
		nxt_beatIdx = beatIdx_ff;
		issue = 1'b0;
		issueWrite = burstWrite_ff;
		issueBank = burstBank_ff;
		issueBeat = beatIdx_ff;
		issueStart = start_ff;
		apClose = BANKS_NONE;
		if (rwOk) begin
			// A new access restarts the burst at its own column.
			nxt_burstOn = 1'b1;
			nxt_burstWrite = isWrite;
			nxt_burstBank = bankIdx;
			nxt_start = cmd.col;
			nxt_beatIdx = COL_RESET;
			// Full page cannot auto-precharge, so A10 is ignored there.
			nxt_apPend = cmd.a10 && !fullPage;
			issue = 1'b1;
			issueWrite = isWrite;
			issueBank = bankIdx;
			issueBeat = COL_RESET;
			issueStart = cmd.col;
		end else if (pmRun && isStop && fullPage && burstOn_ff) begin
			// Stop ends the burst; the bank stays open.
			nxt_burstOn = 1'b0;
			nxt_apPend = 1'b0;
		end else if (pmRun && burstOn_ff) begin
			// No-operation and deselect land here and let it run on.
			if (beatIdx_ff == mask && !fullPage) begin
				nxt_burstOn = 1'b0;
				nxt_apPend = 1'b0;
				// The edge after the last write beat starts precharge.
				if (burstWrite_ff && apPend_ff) begin
					apClose = 4'h1 << burstBank_ff;
				end
			end else begin
				issue = 1'b1;
				issueBeat = beatIdx_ff + 9'h001;
				nxt_beatIdx = issueBeat;
			end
		end
		// Read precharge starts once few enough beats remain.
		if (issue && !issueWrite && nxt_apPend &&
			(mask - issueBeat) <= lead) begin
			apClose = 4'h1 << issueBank;
			nxt_apPend = 1'b0;
		end
		// Upper column bits never receive a carry from the moving bits.
		if (mode.interleave && !fullPage) begin
			issueCol = issueStart ^ (issueBeat & mask);
		end else begin
			issueCol = (issueStart & ~mask) |
				((issueStart + issueBeat) & mask);
		end
		// Bank open and close.
		closeBanks = apClose;
		nxt_bankOpen = bankOpen_ff;
		if (pmRun && isAct) begin
			nxt_bankOpen = bankOpen_ff | bankBit;
		end
		if (pmRun && isPre) begin
			closeBanks = apClose | (cmd.a10 ? BANKS_ALL : bankBit);
		end
		nxt_bankOpen = nxt_bankOpen & ~closeBanks;
		// Read beats walk a latency pipe that freezes in suspend.
		nxt_readPipe = readPipe_ff;
		nxt_beat = beat_ff;
		nxt_beat.readBeat = issue && !issueWrite;
		nxt_beat.writeBeat = issue && issueWrite;
		nxt_beat.bank = issueBank;
		nxt_beat.col = issueCol;
		if (pmRun) begin
			nxt_readPipe = {readPipe_ff[0], issue && !issueWrite};
			nxt_beat.dqOutEn = mode.casLatency3 ? readPipe_ff[1] :
				readPipe_ff[0];
		end
		nxt_status.bankOpen = nxt_bankOpen;
		nxt_status.prechargeBanks = closeBanks;
		nxt_status.selfRefresh = (nxt_pm == PM_SREF);
		nxt_status.powerDown = (nxt_pm == PM_PDOWN);
		nxt_status.clockSuspend = (nxt_pm == PM_SUSP);
		nxt_status.burstActive = nxt_burstOn;
	end

	// Burst, bank and output registers.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bankOpen_ff <= BANKS_NONE;
			burstOn_ff <= 1'b0;
			burstWrite_ff <= 1'b0;
			apPend_ff <= 1'b0;
			burstBank_ff <= 2'h0;
			start_ff <= COL_RESET;
			beatIdx_ff <= COL_RESET;
			readPipe_ff <= 2'h0;
			status_ff <= '0;
			beat_ff <= '0;
		end else if (ce) begin
			bankOpen_ff <= nxt_bankOpen;
			burstOn_ff <= nxt_burstOn;
			burstWrite_ff <= nxt_burstWrite;
			apPend_ff <= nxt_apPend;
			burstBank_ff <= nxt_burstBank;
			start_ff <= nxt_start;
			beatIdx_ff <= nxt_beatIdx;
			readPipe_ff <= nxt_readPipe;
			status_ff <= nxt_status;
			beat_ff <= nxt_beat;
		end
	end

	assign status = status_ff;
	assign beat = beat_ff;

	// ==========================================================
	// Assertions and covers
	// ==========================================================
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	stop_ends_burst_a: assert property (
		ce && pmRun && isStop && fullPage && burstOn_ff && !rwOk
		|=> !burstOn_ff && bankOpen_ff != BANKS_NONE)
		else $error("Burst stop did not end the full-page burst.");
	stop_ignored_a: assert property (
		ce && pmRun && isStop && !fullPage && burstOn_ff &&
		beatIdx_ff != mask |=> burstOn_ff)
		else $error("Burst stop acted on a short burst.");
	read_stop_float_a: assert property (
		(ce && pmRun && isStop && fullPage && burstOn_ff &&
		!burstWrite_ff) ##1 (ce && pmRun && !issue) [*2]
		|=> !beat_ff.dqOutEn)
		else $error("Outputs still driven after read stop.");
	write_stop_drop_a: assert property (
		ce && pmRun && isStop && fullPage && burstWrite_ff && !rwOk
		##1 ce && !rwOk |=> !beat_ff.writeBeat)
		else $error("Write data taken after burst stop.");
	seq_upper_hold_a: assert property (
		issue && !(mode.interleave && !fullPage)
		|-> (issueCol & ~mask) == (issueStart & ~mask))
		else $error("Sequential column carried past boundary.");
	ilv_order_a: assert property (
		issue && mode.interleave && !fullPage
		|-> (issueCol ^ issueStart) == (issueBeat & mask))
		else $error("Interleaved column sequence wrong.");
	wr_ap_close_a: assert property (
		ce && pmRun && burstOn_ff && burstWrite_ff && apPend_ff &&
		beatIdx_ff == mask && !rwOk && !isAct
		|=> !bankOpen_ff[$past(burstBank_ff)])
		else $error("Write auto-precharge did not close the bank.");
	pre_all_a: assert property (
		ce && pmRun && isPre && cmd.a10
		|=> bankOpen_ff == BANKS_NONE && status_ff.prechargeBanks == BANKS_ALL)
		else $error("Precharge all left a bank open.");
	deselect_idle_a: assert property (
		ce && pmRun && cmd.chipSelN && !burstOn_ff && !apPend_ff
		|=> $stable(bankOpen_ff) && !beat_ff.readBeat)
		else $error("Deselect changed device state.");
	suspend_entry_a: assert property (
		ce && pmRun && !cmd.clockEnable && burstOn_ff
		|=> pm_ff == PM_SUSP && status_ff.clockSuspend)
		else $error("Clock suspend not entered during burst.");
	sref_entry_a: assert property (
		ce && pmRun && isSref && bankOpen_ff == BANKS_NONE && !burstOn_ff
		|=> pm_ff == PM_SREF && status_ff.selfRefresh)
		else $error("Self refresh not entered.");
	sref_hold_a: assert property (ce && pm_ff == PM_SREF &&
		!cmd.clockEnable |=> pm_ff == PM_SREF && $stable(bankOpen_ff))
		else $error("Self refresh left while clock enable low.");
	cov_read_ap: cover property (ce && rwOk && isRead && cmd.a10);
	cov_page_stop: cover property (ce && pmRun && isStop && fullPage &&
		burstOn_ff);
	cov_pdown: cover property (pm_ff == PM_PDOWN ##1 pm_ff == PM_RUN);
endmodule

// ==== tb/sdram_ctrl_model.sv ====
// Purpose: Memory controller model that drives the SDRAM command pins.
// Assumes: Its tasks are called just after a rising edge of sys_clk.
// Notes: Spacing counts are small plain defaults, not real timings.

`timescale 1ns/1ps

module sdram_ctrl_model
	import sdram_cmd_pkg::*;
#(
	parameter int GAP = 2,
	parameter int REF_BURST = 2
)(
	input wire logic sys_clk,
	output cmd_pins_t cmd
);
	// ==========================================================
	// Command cycles
	// ==========================================================
	// Deselect with the clock enabled until the first command.
	initial cmd = {4'hF, 1'b1, 12'h000};

	// Drive one command at the edge; returning 1 ns later lets the
	// caller read what the previous command did.
	task cyc(input logic [3:0] ctl, input logic cke, input logic a10,
		input logic [1:0] bk, input logic [8:0] col);
		@(posedge sys_clk);
		cmd <= {ctl, cke, a10, bk, col};
		#1;
	endtask

	// Open a bank, spaced from any earlier precharge and from access.
	task act(input logic [1:0] bk);
		repeat (GAP) cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
		cyc(4'h3, 1'b1, 1'b0, bk, 9'h000);
		repeat (GAP) cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
	endtask

	// Read or write; auto-precharge is never asked in full page.
	task acc(input logic wr, input logic ap, input logic [1:0] bk,
		input logic [8:0] col, input logic page);
		cyc(wr ? 4'h4 : 4'h5, 1'b1, ap & ~page, bk, col);
	endtask

	// Enter self refresh or power down with all banks idle.
	task sleep(input logic sref);
		if (sref) begin
			repeat (REF_BURST) cyc(4'h1, 1'b1, 1'b0, 2'h0, 9'h000);
		end
		cyc(sref ? 4'h1 : 4'h7, 1'b0, 1'b0, 2'h0, 9'h000);
	endtask

	// Raise the clock enable with a no-operation, then wait a cycle.
	task wake;
		cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
		cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
	endtask
endmodule

// ==== tb/tb_sdram_cmd_state.sv ====
// Purpose: Self-checking bench of the SDRAM command and state logic.
// Assumes: The controller model drives cmd; the bench drives mode, ce.
// Notes: Random bursts from a fixed xorshift seed plus corner cases.

`timescale 1ns/1ps

module tb_sdram_cmd_state
	import sdram_cmd_pkg::*;
();
	// ==========================================================
	// Signals and instances
	// ==========================================================
	logic sys_clk;
	logic nrst;
	logic ce;
	mode_cfg_t mode;
	cmd_pins_t cmd;
	dev_status_t status;
	beat_t beat;
	int errors;
	int cmp_count;
	logic [31:0] seed;

	sdram_cmd_state sdram_cmd_state_i (.sys_clk(sys_clk), .nrst(nrst),
		.ce(ce), .cmd(cmd), .mode(mode), .status(status), .beat(beat));
	sdram_ctrl_model sdram_ctrl_model_i (.sys_clk(sys_clk), .cmd(cmd));

	// ==========================================================
	// Helpers
	// ==========================================================
	// Repeatable pseudo-random source.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Column mask of a burst code; unused codes act as single beats.
	function automatic logic [8:0] msk(input logic [2:0] code);
		case (code)
			BL_CODE_2: return MASK_BL2;
			BL_CODE_4: return MASK_BL4;
			BL_CODE_8: return MASK_BL8;
			BL_CODE_PAGE: return MASK_PAGE;
			default: return MASK_BL1;
		endcase
	endfunction

	// Column of beat k in either burst order.
	function automatic logic [8:0] expCol(input logic [8:0] s,
		input logic [8:0] m, input logic il, input int k);
		logic [8:0] kk;
		kk = k[8:0];
		return il ? (s ^ kk) : ((s & ~m) | ((s + kk) & m));
	endfunction

	// Compare one value and count it.
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	// Print the counts and the verdict, then stop.
	task close_out;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ==========================================================
	// Clock and watchdog
	// ==========================================================
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// A hang would stall long before this many cycles pass.
	initial begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		close_out();
	end

	// ==========================================================
	// Scenarios
	// ==========================================================
	initial begin
		logic [31:0] r;
		logic [8:0] m;
		logic [1:0] bk;
		logic [3:0] f;
		int cl;
		int bl;
		errors = 0;
		cmp_count = 0;
		seed = 32'h000012FD;
		nrst = 1'b0;
		ce = 1'b1;
		mode = '0;
		repeat (5) @(posedge sys_clk);
		#1;
		chk(status, 16'h0000);
		chk(beat, 16'h0000);
		@(posedge sys_clk) nrst <= 1'b1;
		// Random bursts; filler is deselect, no-operation or an ignored stop.
		for (int i = 0; i < 14; i++) begin
			r = rnd();
			bk = r[1:0];
			cl = r[2] ? 3 : 2;
			m = msk({1'b0, r[5:4]});
			bl = int'(m) + 1;
			@(posedge sys_clk) mode <= {r[2], r[3], 1'b0, r[5:4]};
			sdram_ctrl_model_i.act(bk);
			chk(status.bankOpen[bk], 1'b1);
			sdram_ctrl_model_i.acc(r[7], r[6], bk, r[16:8], 1'b0);
			for (int k = 0; k < bl; k++) begin
				f = r[k + 17] ? {1'b1, r[2:0]} : (r[6] ? 4'h7 : 4'h6);
				sdram_ctrl_model_i.cyc(f, 1'b1, 1'b0, 2'h0, 9'h000);
				chk(r[7] ? beat.writeBeat : beat.readBeat, 1'b1);
				chk(beat.col, expCol(r[16:8], m, r[3], k));
				chk(beat.bank, bk);
				chk(status.bankOpen[bk], !r[6] || r[7] || k < bl - cl);
				if (!r[7]) chk(beat.dqOutEn, k >= cl - 1);
			end
			sdram_ctrl_model_i.cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
			chk(beat.readBeat | beat.writeBeat, 1'b0);
			chk(status.bankOpen[bk], !r[6]);
			if (r[7]) chk(status.prechargeBanks[bk], r[6]);
			sdram_ctrl_model_i.cyc(4'h2, 1'b1, 1'b0, bk, 9'h000);
			sdram_ctrl_model_i.cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
			if (!r[6]) chk(status.prechargeBanks, 4'h1 << bk);
			chk(status.bankOpen, 4'h0);
		end
		// Single-bank then all-bank precharge.
		for (int b = 0; b < 4; b++) sdram_ctrl_model_i.act(b[1:0]);
		chk(status.bankOpen, 4'hF);
		r = rnd();
		sdram_ctrl_model_i.cyc(4'h2, 1'b1, 1'b0, r[1:0], 9'h000);
		sdram_ctrl_model_i.cyc(4'h2, 1'b1, 1'b1, ~r[1:0], 9'h000);
		chk(status.bankOpen, 4'hF & ~(4'h1 << r[1:0]));
		chk(status.prechargeBanks, 4'h1 << r[1:0]);
		sdram_ctrl_model_i.cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
		chk(status.bankOpen, 4'h0);
		// Full-page read and write, wrapping, then stopped.
		for (int w = 0; w < 2; w++) begin
			r = rnd();
			cl = r[2] ? 3 : 2;
			@(posedge sys_clk) mode <= {r[2], 1'b0, BL_CODE_PAGE};
			sdram_ctrl_model_i.act(2'h1);
			sdram_ctrl_model_i.acc(w[0], 1'b1, 2'h1, 9'h1FC, 1'b1);
			for (int k = 0; k < 6; k++) begin
				sdram_ctrl_model_i.cyc(k == 5 ? 4'h6 : 4'h7, 1'b1, 1'b0,
					2'h0, 9'h000);
				chk(beat.col, expCol(9'h1FC, MASK_PAGE, 1'b0, k));
			end
			sdram_ctrl_model_i.cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
			sdram_ctrl_model_i.cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
			chk(beat.readBeat | beat.writeBeat, 1'b0);
			chk(status.burstActive, 1'b0);
			chk(status.bankOpen[1], 1'b1);
			chk(beat.dqOutEn, w == 0 && cl == 3);
			repeat (cl) sdram_ctrl_model_i.cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
			chk(beat.dqOutEn, 1'b0);
			sdram_ctrl_model_i.cyc(4'h2, 1'b1, 1'b0, 2'h1, 9'h000);
		end
		// Clock enable low in a burst suspends; a read is ignored.
		@(posedge sys_clk) mode <= {1'b0, 1'b0, BL_CODE_8};
		sdram_ctrl_model_i.act(2'h2);
		sdram_ctrl_model_i.acc(1'b0, 1'b0, 2'h2, 9'h000, 1'b0);
		sdram_ctrl_model_i.cyc(4'h7, 1'b0, 1'b0, 2'h0, 9'h000);
		sdram_ctrl_model_i.cyc(4'h5, 1'b0, 1'b0, 2'h2, 9'h000);
		sdram_ctrl_model_i.cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
		chk(status.clockSuspend, 1'b1);
		chk(status.powerDown, 1'b0);
		chk(beat.readBeat, 1'b0);
		sdram_ctrl_model_i.cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
		chk(status.clockSuspend, 1'b0);
		repeat (12) sdram_ctrl_model_i.cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
		sdram_ctrl_model_i.cyc(4'h2, 1'b1, 1'b1, 2'h0, 9'h000);
		// Power down, then self refresh; an activate is ignored in both.
		for (int s = 0; s < 2; s++) begin
			sdram_ctrl_model_i.sleep(s[0]);
			sdram_ctrl_model_i.cyc(4'h3, 1'b0, 1'b0, 2'h3, 9'h000);
			chk(status.powerDown, !s[0]);
			chk(status.selfRefresh, s[0]);
			sdram_ctrl_model_i.wake();
			chk({status.selfRefresh, status.powerDown}, 2'h0);
			chk(status.bankOpen, 4'h0);
		end
		// Block enable low freezes a running burst where it stands.
		sdram_ctrl_model_i.act(2'h0);
		sdram_ctrl_model_i.acc(1'b0, 1'b0, 2'h0, 9'h010, 1'b0);
		sdram_ctrl_model_i.cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
		@(posedge sys_clk) ce <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		chk(beat.col, 9'h011);
		chk(status.burstActive, 1'b1);
		@(posedge sys_clk) ce <= 1'b1;
		sdram_ctrl_model_i.cyc(4'h7, 1'b1, 1'b0, 2'h0, 9'h000);
		chk(beat.col, 9'h012);
		close_out();
	end
endmodule
